// ### hw/cpm_pkg.sv
// Constants, types and register map of the colour/proximity measure control
//=====================================================================
package cpm_pkg;
    //=================================================================
    // Register byte offsets
    localparam logic [7:0] CPM_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CPM_CFG_ADDR = 8'h04;
    localparam logic [7:0] CPM_WAIT_ADDR = 8'h08;
    localparam logic [7:0] CPM_CTHR_ADDR = 8'h0c;
    localparam logic [7:0] CPM_PTHR_ADDR = 8'h10;
    localparam logic [7:0] CPM_STAT_ADDR = 8'h14;
    localparam logic [7:0] CPM_RG_ADDR = 8'h18;
    localparam logic [7:0] CPM_BC_ADDR = 8'h1c;
    localparam logic [7:0] CPM_PRX_ADDR = 8'h20;
    //=================================================================
    // Field positions
    localparam int CPM_EN_BIT = 0;
    localparam int CPM_PEN_BIT = 1;
    localparam int CPM_WEN_BIT = 2;
    localparam int CPM_IEN_BIT = 3;
    localparam int CPM_LED_LSB = 8;
    localparam int CPM_PERS_LSB = 16;
    localparam int CPM_BUSY_BIT = 2;
    //=================================================================
    // Reset values
    localparam logic [4:0] CPM_CTRL_RST = 5'h00;
    localparam logic [23:0] CPM_CFG_RST = 24'h000001;
    localparam logic [11:0] CPM_WAIT_RST = 12'h000;
    localparam logic [31:0] CPM_THR_RST = 32'hffff0000;
    //=================================================================
    // Timing: clock 8 ns, emitter pulse period 14 us, wait unit 2.4 ms
    localparam int CPM_CLK_NS = 8;
    localparam int CPM_PULSE_NS = 14000;
    localparam int CPM_PULSE_CYC = CPM_PULSE_NS / CPM_CLK_NS;
    localparam int CPM_WAIT_UNIT_NS = 2400000;
    localparam int CPM_WAIT_UNIT_CYC = CPM_WAIT_UNIT_NS / CPM_CLK_NS;
    // Emitter sink current codes
    typedef enum logic [1:0] {
        CPM_LED_12MA5, CPM_LED_25MA, CPM_LED_50MA, CPM_LED_100MA
    } cpm_led_e;
    // One simultaneous set of channel results
    typedef struct packed {
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] blue;
        logic [15:0] clear;
    } cpm_result_s;
endpackage : cpm_pkg

// ### hw/cpm_ctrl.sv
// Colour/proximity measurement sequencer with AHB-Lite registers
`timescale 1ns/100ps
module cpm_ctrl #(
    parameter int WAIT_CYC = cpm_pkg::CPM_WAIT_UNIT_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter front end, on its own clock
    input wire logic meas_clk,
    output logic afe_start,
    output logic afe_prox,
    input wire logic afe_done,
    input wire cpm_pkg::cpm_result_s afe_data,
    // Pins
    output logic emit_o,
    output logic emit_oe,
    output logic [1:0] led_sel,
    output logic int_o,
    output logic int_oe
);
    import cpm_pkg::*;

    typedef enum {ST_IDLE, ST_COL, ST_EMIT, ST_PRX, ST_WAIT} cpm_st_e;

    //=================================================================
    // Declarations
    logic wr_q; // Write data phase pending
    logic [7:0] ad_q; // Latched address
    logic [31:0] hrdata_q; // Read data
    logic [31:0] rd_d; // Read mux
    logic acc; // Accepted address phase
    logic [4:0] ctrl_q; // Enables
    logic [23:0] cfg_q; // Pulses, current, persistence
    logic [11:0] wait_q; // Wait units minus one
    logic [31:0] thr_q [2]; // Threshold pairs: 0 colour, 1 proximity
    logic [1:0] flag_q; // Sticky interrupt flags
    logic [1:0] flag_set; // Persistence reached
    logic [1:0] clr; // Software clear
    cpm_result_s res_q; // Live result set
    logic [31:0] bc_sh_q; // Blue/clear snapshot
    logic [15:0] prx_q; // Proximity result
    cpm_st_e st_q; // Sequencer state
    logic req_tgl_q; // Conversion request toggle
    logic req_prox_q; // Request kind
    logic [7:0] pcnt_q; // Pulses emitted
    logic [11:0] tcnt_q; // Cycle within pulse
    logic [11:0] wunit_q; // Wait units elapsed
    logic [31:0] wsub_q; // Cycles within wait unit
    logic [1:0] dsync_q; // Done toggle synchroniser
    logic dprev_q; // Done toggle history
    logic done_ev; // Conversion finished
    logic [1:0] ev; // Conversion finished per path
    logic [15:0] val [2]; // Compared value per path
    logic [1:0] hit; // Threshold event per path
    logic [3:0] pcnt [2]; // Persistence counters
    logic emit_q; // Emitter sink on
    logic int_q; // Interrupt asserted
    // Link domain
    logic [1:0] rsync_q; // Request toggle synchroniser
    logic rprev_q; // Request history
    logic lstart_q; // Start pulse
    logic lprox_q; // Kind for front end
    cpm_result_s lk_q; // Captured front end data
    logic done_tgl_q; // Completion toggle

    //=================================================================
    // AHB-Lite slave: zero wait state, always OKAY
    assign acc = hsel && htrans[1] && hready;
    assign clr = (wr_q && ad_q == CPM_STAT_ADDR) ? hwdata[1:0] : 2'h0;

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (haddr[7:0])
            CPM_CTRL_ADDR: rd_d = {27'h0, ctrl_q};
            CPM_CFG_ADDR: rd_d = {8'h0, cfg_q};
            CPM_WAIT_ADDR: rd_d = {20'h0, wait_q};
            CPM_CTHR_ADDR: rd_d = thr_q[0];
            CPM_PTHR_ADDR: rd_d = thr_q[1];
            CPM_STAT_ADDR: rd_d = {29'h0, st_q != ST_IDLE, flag_q};
            CPM_RG_ADDR: rd_d = {res_q.green, res_q.red};
            CPM_BC_ADDR: rd_d = bc_sh_q;
            CPM_PRX_ADDR: rd_d = {16'h0, prx_q};
            default: rd_d = 32'h0;
        endcase
    end

    // Address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            hrdata_q <= 32'h0;
        end else begin
            wr_q <= acc && hwrite;
            if (acc) begin
                ad_q <= haddr[7:0];
            end
            hrdata_q <= (acc && !hwrite) ? rd_d : 32'h0;
        end
    end

    // Reading red/green freezes blue/clear of the same set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bc_sh_q <= 32'h0;
        end else if (acc && !hwrite && haddr[7:0] == CPM_RG_ADDR) begin
            bc_sh_q <= {res_q.clear, res_q.blue};
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CPM_CTRL_RST;
            cfg_q <= CPM_CFG_RST;
            wait_q <= CPM_WAIT_RST;
            thr_q[0] <= CPM_THR_RST;
            thr_q[1] <= CPM_THR_RST;
        end else if (wr_q) begin
            case (ad_q)
                CPM_CTRL_ADDR: ctrl_q <= hwdata[4:0];
                CPM_CFG_ADDR: cfg_q <= hwdata[23:0];
                CPM_WAIT_ADDR: wait_q <= hwdata[11:0];
                CPM_CTHR_ADDR: thr_q[0] <= hwdata;
                CPM_PTHR_ADDR: thr_q[1] <= hwdata;
                default: ;
            endcase
        end
    end

    //=================================================================
    // Completion crossing from the front end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsync_q <= 2'h0;
            dprev_q <= 1'b0;
        end else begin
            dsync_q <= {dsync_q[0], done_tgl_q};
            dprev_q <= dsync_q[1];
        end
    end
    assign done_ev = dsync_q[1] ^ dprev_q;
    assign ev[0] = done_ev && st_q == ST_COL;
    assign ev[1] = done_ev && st_q == ST_PRX;

    //=================================================================
    // Sequencer: colour, emitter burst, proximity, optional wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
            req_tgl_q <= 1'b0;
            req_prox_q <= 1'b0;
            pcnt_q <= 8'h00;
            tcnt_q <= 12'h000;
            wunit_q <= 12'h000;
            wsub_q <= 32'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (ctrl_q[CPM_EN_BIT]) begin
                        req_tgl_q <= ~req_tgl_q;
                        req_prox_q <= 1'b0;
                        st_q <= ST_COL;
                    end
                end
                ST_COL: begin
                    if (done_ev && ctrl_q[CPM_PEN_BIT]) begin
                        pcnt_q <= 8'h00;
                        tcnt_q <= 12'h000;
                        st_q <= ST_EMIT;
                    end else if (done_ev) begin
                        wunit_q <= 12'h000;
                        wsub_q <= 32'h0;
                        st_q <= ST_WAIT;
                    end
                end
                ST_EMIT: begin
                    // A count of zero still gives one pulse
                    if (tcnt_q == 12'(CPM_PULSE_CYC - 1)) begin
                        tcnt_q <= 12'h000;
                        pcnt_q <= pcnt_q + 8'h01;
                        if ({1'b0, pcnt_q} + 9'h001 >= {1'b0, cfg_q[7:0]}) begin
                            req_tgl_q <= ~req_tgl_q;
                            req_prox_q <= 1'b1;
                            st_q <= ST_PRX;
                        end
                    end else begin
                        tcnt_q <= tcnt_q + 12'h001;
                    end
                end
                ST_PRX: begin
                    if (done_ev) begin
                        wunit_q <= 12'h000;
                        wsub_q <= 32'h0;
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Skipped when wait disabled; else (units+1)*2.4 ms
                    if (!ctrl_q[CPM_WEN_BIT] || (wunit_q == wait_q
                        && wsub_q == 32'(WAIT_CYC - 1))) begin
                        // Next cycle while still enabled
                        if (ctrl_q[CPM_EN_BIT]) begin
                            req_tgl_q <= ~req_tgl_q;
                            req_prox_q <= 1'b0;
                            st_q <= ST_COL;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end else if (wsub_q == 32'(WAIT_CYC - 1)) begin
                        wsub_q <= 32'h0;
                        wunit_q <= wunit_q + 12'h001;
                    end else begin
                        wsub_q <= wsub_q + 32'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Emitter sink: low half of each 14 us period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emit_q <= 1'b0;
        end else begin
            emit_q <= st_q == ST_EMIT && tcnt_q < 12'(CPM_PULSE_CYC / 2);
        end
    end

    //=================================================================
    // Result registers, loaded whole in one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_q <= '0;
            prx_q <= 16'h0;
        end else if (ev[0]) begin
            res_q <= lk_q;
        end else if (ev[1]) begin
            prx_q <= lk_q.red;
        end
    end

    // Thresholds and persistence, one per path
    assign val[0] = lk_q.clear;
    assign val[1] = lk_q.red;
    for (genvar i = 0; i < 2; i++) begin : g_path
        // Outside the window is an event
        assign hit[i] = val[i] > thr_q[i][31:16] || val[i] < thr_q[i][15:0];
        // Five bits so a saturated count of 15 plus one cannot wrap to zero
        assign flag_set[i] = ev[i] && hit[i] && ctrl_q[CPM_IEN_BIT + i]
            && {1'b0, pcnt[i]} + 5'h01 >= {1'b0, cfg_q[CPM_PERS_LSB + 4 * i +: 4]};
        // Consecutive count; any miss restarts it
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pcnt[i] <= 4'h0;
            end else if (ev[i] && !hit[i]) begin
                pcnt[i] <= 4'h0;
            end else if (ev[i] && pcnt[i] != 4'hf) begin
                pcnt[i] <= pcnt[i] + 4'h1;
            end
        end
    end

    // Sticky flags: set wins over the clear write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 2'h0;
            int_q <= 1'b0;
        end else begin
            flag_q <= (flag_q & ~clr) | flag_set;
            int_q <= |((flag_q & ~clr) | flag_set);
        end
    end

    //=================================================================
    // Link domain: request in, result out
    always_ff @(posedge meas_clk or negedge hresetn) begin
        if (!hresetn) begin
            rsync_q <= 2'h0;
            rprev_q <= 1'b0;
            lstart_q <= 1'b0;
            lprox_q <= 1'b0;
            lk_q <= '0;
            done_tgl_q <= 1'b0;
        end else begin
            rsync_q <= {rsync_q[0], req_tgl_q};
            rprev_q <= rsync_q[1];
            lstart_q <= rsync_q[1] ^ rprev_q;
            // Kind is steady long before the toggle arrives
            if (rsync_q[1] ^ rprev_q) begin
                lprox_q <= req_prox_q;
            end
            if (afe_done) begin
                lk_q <= afe_data;
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    //=================================================================
    // Outputs; open-drain pins drive low only
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign afe_start = lstart_q;
    assign afe_prox = lprox_q;
    assign emit_o = 1'b0;
    assign emit_oe = emit_q;
    assign led_sel = cfg_q[CPM_LED_LSB +: 2];
    assign int_o = 1'b0;
    assign int_oe = int_q;

    //=================================================================
    // Checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_result_load: assert property (ev[0] |=> res_q == $past(lk_q))
        else $error("result set not loaded");
    a_result_hold: assert property (!ev[0] |=> $stable(res_q))
        else $error("result set changed between loads");
    a_int_level: assert property (int_oe && clr == 2'h0 |=> int_oe)
        else $error("interrupt dropped without clear");
    a_int_clear_write: assert property ($fell(int_oe) |-> $past(clr != 2'h0))
        else $error("interrupt released without write");
    a_persist_restart: assert property (ev[0] && !hit[0] |=> pcnt[0] == 4'h0)
        else $error("persistence not restarted");
    a_path_apart: assert property (ev[0] |=> $stable(pcnt[1]))
        else $error("proximity count moved on colour");
    a_thr_fire: assert property (ev[1] && val[1] > thr_q[1][31:16]
        && ctrl_q[4] && cfg_q[23:20] == 4'h0 |=> int_oe)
        else $error("proximity event did not interrupt");
    a_emit_width: assert property ($rose(emit_oe) |-> emit_oe[*8])
        else $error("emitter pulse too short");
    a_emit_state: assert property (emit_oe |-> $past(st_q == ST_EMIT))
        else $error("emitter on outside burst");
    a_burst_count: assert property ($rose(st_q == ST_PRX)
        |-> $past(pcnt_q) + 8'h01 >= cfg_q[7:0])
        else $error("burst ended early");
    a_led_follow: assert property ($changed(led_sel)
        |-> $past(wr_q && ad_q == CPM_CFG_ADDR))
        else $error("current select moved without config write");
endmodule : cpm_ctrl

// ### verification/cpm_afe_model.sv
// Behavioural converter front end answering conversion requests on the link clock
`timescale 1ns/100ps
module cpm_afe_model
    import cpm_pkg::*;
(
    // Link clock and reset
    input wire logic meas_clk,
    input wire logic rst_n,
    // Request side
    input wire logic afe_start,
    input wire logic slow,
    input wire cpm_pkg::cpm_result_s data_in,
    // Answer side
    output logic afe_done,
    output cpm_pkg::cpm_result_s afe_data
);
    //=================================================================
    // State
    int cnt; // Cycles left before the answer
    logic pend_q; // A request is outstanding
    //=================================================================
    // Answer one cycle of done per start; data invert outside done so stale
    // values never look valid
    always_ff @(posedge meas_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            cnt <= 0;
            afe_done <= 1'b0;
            afe_data <= '0;
        end else begin
            afe_done <= 1'b0;
            afe_data <= ~afe_data;
            if (afe_start) begin
                // Slow answers stretch the crossing window
                pend_q <= 1'b1;
                cnt <= slow ? 40 : 1;
            end else if (pend_q && cnt == 0) begin
                // All four channels handed over as one set
                pend_q <= 1'b0;
                afe_done <= 1'b1;
                afe_data <= data_in;
            end else if (pend_q) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : cpm_afe_model

// ### verification/tb_cpm_ctrl.sv
// Self-checking bench for the measurement sequencer with a behavioural model
`timescale 1ns/100ps
module tb_cpm_ctrl
    import cpm_pkg::*;
;
    //=================================================================
    // Signals
    logic hclk = 1'b0, meas_clk = 1'b0, hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, slow = 1'b0;
    logic [1:0] htrans = 2'h0, led_sel;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, cfg_v, cthr, pthr;
    logic afe_start, afe_prox, afe_done, emit_o, emit_oe, int_o, int_oe, ev, prev_e = 1'b0;
    cpm_result_s afe_data, set_v, data_in = '0;
    logic [4:0] ctrl_v = 5'h00; // Enables as software wrote them at the start of the last run
    logic [31:0] seed = 32'h19; // Xorshift state
    int failures = 0, checks = 0, dones = 0, cyc = 0, stamp = -1, min_gap = 1000000;
    int ccnt = 0, pcnt = 0, edges = 0, hi_cyc = 0, e0, h0, np;
    logic cflag = 1'b0, pflag = 1'b0; // Model interrupt flags
    logic [15:0] clr_t [5] = '{16'hf800, 16'h8000, 16'h0050, 16'hffff, 16'h8000};
    logic [15:0] prx_t [4] = '{16'h0300, 16'h0008, 16'h0100, 16'h0400};
    logic [31:0] rst_a [7] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10, 32'h14, 32'h30};
    logic [31:0] rst_v [7] = '{32'h0, 32'h1, 32'h0, 32'hffff0000, 32'hffff0000, 32'h0, 32'h0};
    assign hready = hreadyout;
    // Clocks: link clock unrelated in phase to the bus clock
    always #4 hclk = ~hclk;
    initial #7 forever #15 meas_clk = ~meas_clk;
    //=================================================================
    // Design and far side
    cpm_ctrl #(.WAIT_CYC(20)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas_clk(meas_clk), .afe_start(afe_start), .afe_prox(afe_prox),
        .afe_done(afe_done), .afe_data(afe_data), .emit_o(emit_o), .emit_oe(emit_oe),
        .led_sel(led_sel), .int_o(int_o), .int_oe(int_oe));
    cpm_afe_model u_afe (.meas_clk(meas_clk), .rst_n(hresetn), .afe_start(afe_start),
        .slow(slow), .data_in(data_in), .afe_done(afe_done), .afe_data(afe_data));
    //=================================================================
    // Emitter pulse counting on the bus clock
    always @(posedge hclk) begin
        cyc++;
        prev_e <= emit_oe;
        if (emit_oe === 1'b1) hi_cyc++;
        if (emit_oe === 1'b1 && prev_e === 1'b0) edges++;
    end
    // Behavioural model: wait gap, events and persistence per path
    always @(posedge meas_clk) begin
        if (afe_start === 1'b1 && stamp >= 0 && cyc - stamp < min_gap) min_gap = cyc - stamp;
        if (afe_done === 1'b1) begin
            dones++;
            stamp = cyc;
            if (afe_prox === 1'b1) begin
                ev = afe_data.red > pthr[31:16] || afe_data.red < pthr[15:0];
                pcnt = ev ? (pcnt < 15 ? pcnt + 1 : 15) : 0;
                if (ev && pcnt >= cfg_v[23:20] && ctrl_v[4]) pflag = 1'b1;
            end else begin
                ev = afe_data.clear > cthr[31:16] || afe_data.clear < cthr[15:0];
                ccnt = ev ? (ccnt < 15 ? ccnt + 1 : 15) : 0;
                if (ev && ccnt >= cfg_v[19:16] && ctrl_v[3]) cflag = 1'b1;
            end
        end
    end
    //=================================================================
    // Helpers
    function automatic logic [31:0] xs_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs_next
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task tmo(input int n);
        if (n >= 20000) begin
            failures++;
            $display("wait limit reached");
            print_verdict();
        end
    endtask : tmo
    // One single-word transfer: address phase, then data phase
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20000);
        tmo(n);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20000);
        tmo(n);
        r = hrdata;
    endtask : ahb
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(1'b1, a, d, t);
    endtask : wr
    // Enable, let n conversions finish, drop the enable and wait for idle
    task run(input logic [4:0] c, input int n);
        int d0, k;
        ctrl_v = c;
        wr(CPM_CTRL_ADDR, {27'h0, c});
        d0 = dones;
        k = 0;
        while (dones < d0 + n && k < 20000) begin @(posedge hclk); k++; end
        tmo(k);
        wr(CPM_CTRL_ADDR, {27'h0, c & 5'h1e});
        k = 0;
        do begin ahb(1'b0, CPM_STAT_ADDR, 32'h0, rd); k++; end while (rd[2] !== 1'b0 && k < 300);
        tmo((rd[2] !== 1'b0) ? 20000 : 0);
    endtask : run
    //=================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, rst_a[i], 32'h0, rd);
            check("reset value", rd, rst_v[i]);
            check("bus response", {31'h0, hresp}, 32'h0);
        end
        wr(32'h30, 32'hffffffff);
        ahb(1'b0, 32'h30, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        cthr = 32'hf0000100;
        pthr = 32'h02000010;
        cfg_v = 32'h00020000;
        wr(CPM_WAIT_ADDR, 32'h2);
        wr(CPM_CTHR_ADDR, cthr);
        wr(CPM_PTHR_ADDR, pthr);
        wr(CPM_CFG_ADDR, cfg_v);
        // Colour path: threshold above and below, persistence of two, restart on miss
        for (int i = 0; i < 5; i++) begin
            set_v = {xs_next(), xs_next()};
            set_v.clear = clr_t[i];
            data_in <= set_v;
            slow <= i[0];
            run(5'h0d, 1);
            ahb(1'b0, CPM_RG_ADDR, 32'h0, rd);
            check("red green", rd, {set_v.green, set_v.red});
            ahb(1'b0, CPM_BC_ADDR, 32'h0, rd);
            check("blue clear", rd, {set_v.clear, set_v.blue});
            ahb(1'b0, CPM_STAT_ADDR, 32'h0, rd);
            check("colour flag", {31'h0, rd[0]}, {31'h0, cflag});
            check("int pin", {31'h0, int_oe}, {31'h0, cflag | pflag});
        end
        wr(CPM_STAT_ADDR, 32'h1);
        cflag = 1'b0;
        ahb(1'b0, CPM_STAT_ADDR, 32'h0, rd);
        check("flag cleared", {30'h0, rd[1:0]}, 32'h0);
        check("int released", {31'h0, int_oe}, 32'h0);
        // Repeating cycles with a wait between them
        run(5'h05, 3);
        check("wait gap", {31'h0, min_gap >= 60}, 32'h1);
        // Proximity path: every current code, several burst lengths
        for (int k = 0; k < 4; k++) begin
            cfg_v = 32'h00020000 | (k << 8) | k;
            wr(CPM_CFG_ADDR, cfg_v);
            set_v = {prx_t[k], xs_next(), 16'h8000};
            data_in <= set_v;
            e0 = edges;
            h0 = hi_cyc;
            run(5'h17, 2);
            np = k == 0 ? 1 : k;
            check("current code", {30'h0, led_sel}, k);
            check("pulse count", edges - e0, np);
            check("pulse time", hi_cyc - h0, np * 875);
            check("emit level", {31'h0, emit_o}, 32'h0);
            ahb(1'b0, CPM_PRX_ADDR, 32'h0, rd);
            check("prox value", rd, {16'h0, set_v.red});
            ahb(1'b0, CPM_STAT_ADDR, 32'h0, rd);
            check("status flags", {30'h0, rd[1:0]}, {30'h0, pflag, cflag});
            check("int pin prox", {31'h0, int_oe}, {31'h0, pflag});
            wr(CPM_STAT_ADDR, 32'h2);
            pflag = 1'b0;
            check("int low level", {31'h0, int_o}, 32'h0);
        end
        print_verdict();
    end
endmodule : tb_cpm_ctrl
